// File: design/dcd_top.v
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "dcd_defs.vh"

module dcd_top #(
  parameter SAMPLE_CYC = `DCD_SAMPLE_CYC,
  parameter REF_UNIT_CYC = `DCD_REF_UNIT_CYC,
  parameter FIFO_DEPTH = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ev_ch0_i,
  input wire ev_ch1_i,
  output reg [11:0] ch0_value_o,
  output reg [11:0] ch1_value_o,
  output reg ch0_drive_o,
  output reg ch1_drive_o,
  output reg ch0_sample_o,
  output reg ch1_sample_o,
  output reg busy_o
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam [10:0] REF_UNIT = REF_UNIT_CYC[10:0]; // refresh step in cycles
  localparam [7:0] SAMPLE_LEN = SAMPLE_CYC[7:0]; // sample interval in cycles
  localparam CONV_IDLE = 1'b0; // converter free
  localparam CONV_BUSY = 1'b1; // sample interval running

  reg [7:0] control_register_b; // channel select
  reg [7:0] control_register_c; // left adjust
  reg [7:0] timing_control_register; // refresh period
  reg [7:0] ch0_low_reg; // channel 0 low byte
  reg [7:0] ch0_high_reg; // channel 0 high byte
  reg [7:0] ch1_low_reg; // channel 1 low byte
  reg [7:0] ch1_high_reg; // channel 1 high byte
  reg req0_reg; // channel 0 conversion asked
  reg req1_reg; // channel 1 conversion asked
  reg ref0_reg; // channel 0 refresh due
  reg ref1_reg; // channel 1 refresh due
  reg [10:0] ref_cnt_reg; // free running refresh timer
  reg conv_state_reg; // converter state
  reg [7:0] conv_cnt_reg; // sample interval count
  reg conv_ch_reg; // channel being sampled

  wire channel_select_field; // 1 = dual
  wire left_adjust_bit; // 1 = left adjusted
  wire [3:0] refresh_field; // 0 = refresh off
  wire wb_req; // bus access under way
  wire wb_wr; // write takes effect now
  wire lane0; // low byte lane enabled
  wire wr_ch0_high; // channel 0 high byte write
  wire wr_ch1_high; // channel 1 high byte write
  wire [11:0] ch0_val; // assembled channel 0 value
  wire [11:0] ch1_val; // assembled channel 1 value
  wire [10:0] ref_period; // refresh period in cycles
  wire ref_tick; // refresh interval elapsed
  wire push_valid; // something to queue
  wire push_ready; // fifo has room
  wire push_ch; // channel to queue
  wire [12:0] push_word; // {channel, value}
  wire pop_valid; // queued conversion waiting
  wire pop_ready; // converter takes it
  wire [12:0] pop_word; // next conversion
  wire take_req0; // queue request 0 now
  wire take_req1; // queue request 1 now
  wire take_ref0; // queue refresh 0 now
  wire take_ref1; // queue refresh 1 now
  reg [31:0] rd_data; // read mux

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  assign channel_select_field = control_register_b[`DCD_CHANNEL_SELECT_FIELD_BIT];
  assign left_adjust_bit = control_register_c[`DCD_LEFT_ADJUST_BIT_BIT];
  assign refresh_field = timing_control_register[`DCD_REFRESH_MSB:`DCD_REFRESH_LSB];

  // value assembly from byte pairs
  assign ch0_val = left_adjust_bit ? {ch0_high_reg, ch0_low_reg[7:4]}
                                   : {ch0_high_reg[3:0], ch0_low_reg};
  assign ch1_val = left_adjust_bit ? {ch1_high_reg, ch1_low_reg[7:4]}
                                   : {ch1_high_reg[3:0], ch1_low_reg};

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign wr_ch0_high = wb_wr & lane0 & (wb_adr_i == `DCD_OFS_CH0_HIGH);
  assign wr_ch1_high = wb_wr & lane0 & (wb_adr_i == `DCD_OFS_CH1_HIGH);

  // read mux, unmapped reads zero
  always @* begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `DCD_OFS_CONTROL_REGISTER_B: rd_data = {24'h000000, control_register_b};
      `DCD_OFS_CONTROL_REGISTER_C: rd_data = {24'h000000, control_register_c};
      `DCD_OFS_TIMING: rd_data = {24'h000000, timing_control_register};
      `DCD_OFS_CH0_LOW: rd_data = {24'h000000, ch0_low_reg};
      `DCD_OFS_CH0_HIGH: rd_data = {24'h000000, ch0_high_reg};
      `DCD_OFS_CH1_LOW: rd_data = {24'h000000, ch1_low_reg};
      `DCD_OFS_CH1_HIGH: rd_data = {24'h000000, ch1_high_reg};
      `DCD_OFS_STATUS: rd_data = {24'h000000, pop_valid, conv_ch_reg, conv_state_reg,
                                  ~push_ready, ref1_reg, ref0_reg, req1_reg, req0_reg};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ack one cycle after request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // register writes on the acknowledged edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      control_register_b <= `DCD_CONTROL_REGISTER_B_RST;
      control_register_c <= `DCD_CONTROL_REGISTER_C_RST;
      timing_control_register <= `DCD_TIMING_RST;
      ch0_low_reg <= `DCD_DATA_RST;
      ch0_high_reg <= `DCD_DATA_RST;
      ch1_low_reg <= `DCD_DATA_RST;
      ch1_high_reg <= `DCD_DATA_RST;
    end else if (wb_wr & lane0) begin
      case (wb_adr_i)
        `DCD_OFS_CONTROL_REGISTER_B: control_register_b <= wb_dat_i[7:0];
        `DCD_OFS_CONTROL_REGISTER_C: control_register_c <= wb_dat_i[7:0];
        `DCD_OFS_TIMING: timing_control_register <= wb_dat_i[7:0];
        `DCD_OFS_CH0_LOW: ch0_low_reg <= wb_dat_i[7:0];
        `DCD_OFS_CH0_HIGH: ch0_high_reg <= wb_dat_i[7:0];
        `DCD_OFS_CH1_LOW: ch1_low_reg <= wb_dat_i[7:0];
        `DCD_OFS_CH1_HIGH: ch1_high_reg <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // refresh interval generator
  // ----------------------------------------
  assign ref_period = {7'h00, refresh_field} * REF_UNIT;
  assign ref_tick = channel_select_field & (refresh_field != 4'h0) &
                    (ref_cnt_reg >= ref_period - 11'h001);

  // free running, only the period and mode touch it
  always @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt_reg <= 11'h000;
    end else if (ref_tick | ~channel_select_field | (refresh_field == 4'h0)) begin
      ref_cnt_reg <= 11'h000;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 11'h001;
    end
  end

  // ----------------------------------------
  // pending requests and queue feed
  // ----------------------------------------
  // priority: asked conversions, then refresh ch0, then ch1
  assign take_req0 = push_ready & req0_reg;
  assign take_req1 = push_ready & ~req0_reg & req1_reg;
  assign take_ref0 = push_ready & ~req0_reg & ~req1_reg & ref0_reg;
  assign take_ref1 = push_ready & ~req0_reg & ~req1_reg & ~ref0_reg & ref1_reg;
  assign push_valid = req0_reg | req1_reg | ref0_reg | ref1_reg;
  assign push_ch = ~(req0_reg | (~req1_reg & ref0_reg));
  assign push_word = {push_ch, push_ch ? ch1_val : ch0_val};

  // flags: a new set wins over its own clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      req0_reg <= 1'b0;
      req1_reg <= 1'b0;
      ref0_reg <= 1'b0;
      ref1_reg <= 1'b0;
    end else begin
      req0_reg <= (req0_reg & ~take_req0) | wr_ch0_high | ev_ch0_i;
      req1_reg <= (req1_reg & ~take_req1 & channel_select_field) |
                  (channel_select_field & (wr_ch1_high | ev_ch1_i));
      ref0_reg <= (ref0_reg & ~take_ref0 & channel_select_field) | ref_tick;
      ref1_reg <= (ref1_reg & ~take_ref1 & channel_select_field) | ref_tick;
    end
  end

  // ----------------------------------------
  // conversion queue
  // ----------------------------------------
  dcd_fifo #(
    .WIDTH(13),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_word),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_word)
  );

  // converter accepts only when idle, so the queue can fill
  assign pop_ready = (conv_state_reg == CONV_IDLE);

  // ----------------------------------------
  // shared conversion block
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      conv_state_reg <= CONV_IDLE;
      conv_cnt_reg <= 8'h00;
      conv_ch_reg <= 1'b0;
      ch0_value_o <= 12'h000;
      ch1_value_o <= 12'h000;
      ch0_sample_o <= 1'b0;
      ch1_sample_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      case (conv_state_reg)
        CONV_IDLE: begin
          ch0_sample_o <= 1'b0;
          ch1_sample_o <= 1'b0;
          busy_o <= 1'b0;
          if (pop_valid) begin
            conv_state_reg <= CONV_BUSY;
            conv_cnt_reg <= 8'h00;
            busy_o <= 1'b1;
            if (~channel_select_field) begin
              conv_ch_reg <= 1'b0;
              ch0_value_o <= pop_word[11:0];
            end else if (pop_word[12]) begin
              conv_ch_reg <= 1'b1;
              ch1_value_o <= pop_word[11:0];
              ch1_sample_o <= 1'b1;
            end else begin
              conv_ch_reg <= 1'b0;
              ch0_value_o <= pop_word[11:0];
              ch0_sample_o <= 1'b1;
            end
          end
        end
        CONV_BUSY: begin
          // one sample interval per conversion
          if (conv_cnt_reg >= SAMPLE_LEN - 8'h01) begin
            conv_state_reg <= CONV_IDLE;
            ch0_sample_o <= 1'b0;
            ch1_sample_o <= 1'b0;
            busy_o <= 1'b0;
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 8'h01;
          end
        end
        default: begin
          conv_state_reg <= CONV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // output drivers
  // ----------------------------------------
  // single: ch0 driven always, no hold; dual: both held outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      ch0_drive_o <= 1'b0;
      ch1_drive_o <= 1'b0;
    end else begin
      ch0_drive_o <= 1'b1;
      ch1_drive_o <= channel_select_field;
    end
  end
endmodule // dcd_top

// File: design/dcd_defs.vh
`ifndef DCD_DEFS_VH
`define DCD_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCD_OFS_CONTROL_REGISTER_B 5'h00
`define DCD_OFS_CONTROL_REGISTER_C 5'h04
`define DCD_OFS_TIMING 5'h08
`define DCD_OFS_CH0_LOW 5'h0C
`define DCD_OFS_CH0_HIGH 5'h10
`define DCD_OFS_CH1_LOW 5'h14
`define DCD_OFS_CH1_HIGH 5'h18
`define DCD_OFS_STATUS 5'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define DCD_CHANNEL_SELECT_FIELD_BIT 0
`define DCD_LEFT_ADJUST_BIT_BIT 0
`define DCD_REFRESH_LSB 0
`define DCD_REFRESH_MSB 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define DCD_CONTROL_REGISTER_B_RST 8'h00
`define DCD_CONTROL_REGISTER_C_RST 8'h00
`define DCD_TIMING_RST 8'h00
`define DCD_DATA_RST 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define DCD_CLK_NS 100
`define DCD_SAMPLE_NS 1000
`define DCD_REF_UNIT_NS 6400
`define DCD_SAMPLE_CYC ((`DCD_SAMPLE_NS + `DCD_CLK_NS - 1) / `DCD_CLK_NS)
`define DCD_REF_UNIT_CYC ((`DCD_REF_UNIT_NS + `DCD_CLK_NS - 1) / `DCD_CLK_NS)

`endif

// File: design/dcd_fifo.v
`timescale 1ns/1ps

// ----------------------------------------
// small request fifo with valid/ready on both sides
// ----------------------------------------
module dcd_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
  reg [AW-1:0] wr_ptr_reg; // write pointer
  reg [AW-1:0] rd_ptr_reg; // read pointer
  reg [AW:0] count_reg; // words held
  wire push; // word accepted
  wire pop; // word delivered

  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // storage write, no reset needed
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and fill count
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // dcd_fifo

// File: verification/dcd_props.sv
`timescale 1ns/1ps
`include "dcd_defs.vh"
// ----------------------------------------
// port checker for the converter control
// ----------------------------------------
module dcd_props #(
  parameter SAMPLE_CYC = 10,
  parameter REF_UNIT_CYC = 64,
  parameter FIFO_DEPTH = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire ev_ch0_i,
  input wire ev_ch1_i,
  input wire [11:0] ch0_value_o,
  input wire [11:0] ch1_value_o,
  input wire ch0_drive_o,
  input wire ch1_drive_o,
  input wire ch0_sample_o,
  input wire ch1_sample_o,
  input wire busy_o
);
  reg [7:0] run_reg; // length of the current busy run
  // count busy cycles, cleared when idle
  always @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      run_reg <= 8'h00;
    end else begin
      run_reg <= run_reg + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  drive_cont_a: assert property (!$past(rst_i) |-> ch0_drive_o) else $error("ch0 drive lost");
  sample_excl_a: assert property (!(ch0_sample_o && ch1_sample_o)) else $error("both sampling");
  ch1_hold_a: assert property (!$past(rst_i) && $changed(ch1_value_o) |-> ch1_sample_o)
    else $error("ch1 changed outside sample");
  ch0_cause_a: assert property (!$past(rst_i) && $changed(ch0_value_o) |-> busy_o) else $error("ch0 idle change");
  write_conv_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `DCD_OFS_CH0_HIGH
    |-> ##[1:40] busy_o) else $error("write started no conversion");
  event_conv_a: assert property (ev_ch0_i |-> ##[1:40] busy_o) else $error("event started no conversion");
  busy_len_a: assert property ($fell(busy_o) |-> run_reg >= SAMPLE_CYC) else $error("sample interval short");
  cov_ch1_c: cover property ($rose(ch1_sample_o));
  cov_ev_c: cover property (ev_ch0_i ##[1:10] busy_o);
  cov_pair_c: cover property ($fell(ch0_sample_o) ##[0:3] ch1_sample_o);
endmodule // dcd_props

bind dcd_top dcd_props #(.SAMPLE_CYC(SAMPLE_CYC), .REF_UNIT_CYC(REF_UNIT_CYC), .FIFO_DEPTH(FIFO_DEPTH)) props_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ev_ch0_i(ev_ch0_i), .ev_ch1_i(ev_ch1_i), .ch0_value_o(ch0_value_o), .ch1_value_o(ch1_value_o),
  .ch0_drive_o(ch0_drive_o), .ch1_drive_o(ch1_drive_o), .ch0_sample_o(ch0_sample_o),
  .ch1_sample_o(ch1_sample_o), .busy_o(busy_o));

// File: verification/dcd_ev_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// event routing model: strobe in, one-cycle event out
// ----------------------------------------
module dcd_ev_src (
  input wire clk_i,
  input wire rst_i,
  input wire go0_i,
  input wire go1_i,
  output reg ev0_o,
  output reg ev1_o
);
  // registered pulses in the converter's clock domain
  always @(posedge clk_i) begin
    ev0_o <= rst_i ? 1'b0 : go0_i;
    ev1_o <= rst_i ? 1'b0 : go1_i;
  end
endmodule // dcd_ev_src

// File: verification/tb.sv
`timescale 1ns/1ps
`include "dcd_defs.vh"
module tb;
  localparam SC = 4; // shortened sample interval
  localparam RU = 16; // shortened refresh unit
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [3:0] sel = 4'h0; // byte enables, raised with the request
  reg [4:0] adr = 5'h00;
  reg [31:0] dat = 32'h0;
  reg go0 = 1'b0;
  reg go1 = 1'b0;
  wire ev0, ev1, ack, c0d, c1d, c0s, c1s, busy;
  wire [31:0] rdat;
  wire [11:0] v0, v1;
  integer n_fail = 0;
  integer num_checks = 0;
  integer cyc_cnt = 0;
  reg [7:0] rd;
  dcd_top #(.SAMPLE_CYC(SC), .REF_UNIT_CYC(RU), .FIFO_DEPTH(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ev_ch0_i(ev0), .ev_ch1_i(ev1), .ch0_value_o(v0), .ch1_value_o(v1),
    .ch0_drive_o(c0d), .ch1_drive_o(c1d), .ch0_sample_o(c0s), .ch1_sample_o(c1s), .busy_o(busy));
  dcd_ev_src ev_u (.clk_i(clk_i), .rst_i(rst_i), .go0_i(go0), .go1_i(go1), .ev0_o(ev0), .ev1_o(ev1));
  always #50 clk_i = ~clk_i;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task complete_run;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    sel <= 4'h0;
  endtask
  // wait until the converter stays idle for eight cycles
  task quiet;
    integer q;
    q = 0;
    while (q < 8) begin
      @(posedge clk_i);
      q = (busy === 1'b0) ? q + 1 : 0;
    end
  endtask
  // wait for a rising sample flag, cycle count returned
  task rise(input logic ch, output integer t);
    logic p;
    p = 1'b1;
    while (!(p === 1'b0 && (ch ? c1s : c0s) === 1'b1)) begin
      p = ch ? c1s : c0s;
      @(posedge clk_i);
    end
    t = cyc_cnt;
  endtask
  task pulse(input logic ch);
    @(posedge clk_i);
    if (ch) go1 <= 1'b1; else go0 <= 1'b1;
    @(posedge clk_i);
    go0 <= 1'b0; go1 <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    for (int a = 0; a < 32; a = a + 4) begin
      xfer(1'b0, a[4:0], 8'h00);
      chk(rd, 8'h00);
    end
    chk(c0d, 1'b1);
    chk(c1d, 1'b0);
  endtask
  task t_single;
    xfer(1'b1, `DCD_OFS_CH0_LOW, 8'hA5);
    // a wrongly started conversion would still be busy here
    repeat (4) @(posedge clk_i);
    chk(busy, 1'b0);
    xfer(1'b1, `DCD_OFS_CH0_HIGH, 8'hFC);
    quiet;
    chk(v0, 12'hCA5);
    xfer(1'b1, `DCD_OFS_CH1_LOW, 8'h11);
    xfer(1'b1, `DCD_OFS_CH1_HIGH, 8'h02);
    quiet;
    chk(v0, 12'hCA5);
    chk({v1, c1s}, 13'h0000);
  endtask
  task t_left;
    xfer(1'b1, `DCD_OFS_CONTROL_REGISTER_C, 8'h01);
    xfer(1'b0, `DCD_OFS_CONTROL_REGISTER_C, 8'h00);
    chk(rd, 8'h01);
    xfer(1'b1, `DCD_OFS_CH0_LOW, 8'h9F);
    xfer(1'b1, `DCD_OFS_CH0_HIGH, 8'hB7);
    quiet;
    chk(v0, 12'hB79);
    xfer(1'b1, `DCD_OFS_CH0_HIGH, 8'h40);
    quiet;
    chk(v0, 12'h409);
    xfer(1'b1, `DCD_OFS_CONTROL_REGISTER_C, 8'h00);
  endtask
  task t_event;
    pulse(1'b0);
    quiet;
    chk(v0, 12'h09F);
    pulse(1'b1);
    // look inside the window where a stray conversion would run
    repeat (4) @(posedge clk_i);
    chk(busy, 1'b0);
  endtask
  task t_dual;
    integer t;
    xfer(1'b1, `DCD_OFS_CONTROL_REGISTER_B, 8'h01);
    quiet;
    chk(c1d, 1'b1);
    xfer(1'b1, `DCD_OFS_CH1_LOW, 8'h34);
    xfer(1'b1, `DCD_OFS_CH1_HIGH, 8'h02);
    rise(1'b1, t);
    chk(c0s, 1'b0);
    quiet;
    chk(v1, 12'h234);
    chk(v0, 12'h09F);
  endtask
  task t_refresh;
    integer t0, t1, t2;
    xfer(1'b1, `DCD_OFS_TIMING, 8'h02);
    rise(1'b0, t0);
    rise(1'b1, t1);
    chk(t1 - t0 <= SC + 4, 1'b1);
    chk({v0, v1}, {12'h09F, 12'h234});
    pulse(1'b1);
    rise(1'b0, t1);
    chk(t1 - t0, 2 * RU);
    xfer(1'b1, `DCD_OFS_CH0_LOW, 8'h66);
    while (cyc_cnt < t1 + 2 * RU - 3) @(posedge clk_i);
    xfer(1'b1, `DCD_OFS_CH0_HIGH, 8'h07);
    rise(1'b1, t2);
    chk(t2 - t1 <= 2 * RU + 4 * SC + 12, 1'b1);
    quiet;
    chk(v0, 12'h766);
    xfer(1'b1, `DCD_OFS_TIMING, 8'h00);
  endtask
  // ----------------------------------------
  // hang guard and main sequence
  // ----------------------------------------
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt > 20000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_single;
    t_left;
    t_event;
    t_dual;
    t_refresh;
    complete_run;
  end
endmodule // tb
